// [src/cci2c_top.sv]
// Functional notes
// - Seven-bit link timeout, 2 ms steps, resets 0x7F
// - Abort link transaction exceeding programmed timeout
// - Timeout disable bit stops watchdog, resets 0
// - Block bit refuses remote local-register writes
// - SDA input hold after SCL, 50 ns steps
// - Reject SCL/SDA glitches up to depth times 5 ns
// - Remote ACK SDA setup 80 ns plus 640 ns steps
// - SDA output delay 240 ns plus 40 ns steps
// - Bus guard 50 us fast, 1 s default
// - SDA high and idle means bus free
// - SDA low and idle: drive nine SCL pulses
module cci2c_top #(
	parameter int LINK_TICK_CYC = cci2c_pkg::LINK_TICK_CYC,
	parameter int GUARD_FAST_CYC = cci2c_pkg::GUARD_FAST_CYC,
	parameter int GUARD_SLOW_CYC = cci2c_pkg::GUARD_SLOW_CYC,
	parameter int RECOVER_HALF_CYC = cci2c_pkg::RECOVER_HALF_CYC
) (
	// Clocks and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic                  link_clk,
	// Local register port
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	// Control link side, link clock
	input  wire logic                  link_txn_active,
	input  wire logic                  link_wr_req,
	input  wire cci2c_pkg::cci2c_wr_t  link_wr,
	output logic                       link_wr_busy,
	output logic                       link_wr_refused,
	output logic                       link_abort,
	// Device core side
	input  wire logic                  core_sda_low,
	input  wire logic                  core_ack_cycle,
	// Local bus pins
	input  wire cci2c_pkg::cci2c_pins_t bus_in,
	output cci2c_pkg::cci2c_pins_t     bus_o,
	output cci2c_pkg::cci2c_pins_t     bus_oe,
	// Status
	output cci2c_pkg::cci2c_pins_t     bus_seen,
	output logic                       bus_free,
	output logic                       bus_recovering
);
	import cci2c_pkg::*;

	if (LINK_TICK_CYC < 2 || GUARD_FAST_CYC < 2 || GUARD_SLOW_CYC < 2
		|| RECOVER_HALF_CYC < 2 || RECOVER_HALF_CYC > 1023) begin : g_chk
		$error("cci2c_top: unusable timing parameter");
	end

	function automatic int cyc_of(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_of

	typedef enum logic [1:0] {O_IDLE, O_DELAY, O_SETUP} cci2c_out_t;
	typedef enum logic [1:0] {G_WATCH, G_REC_LO, G_REC_HI} cci2c_guard_t;

	logic [7:0]   wd_reg;
	logic [7:0]   ctl1;
	logic [7:0]   ctl2;
	logic         wr_go;
	logic [7:0]   wr_a;
	logic [7:0]   wr_d;
	logic         rem_go;
	logic         rem_pend;
	logic         rem_refused;
	logic         blocked;
	cci2c_wr_t    wr_hold;
	logic         req_tgl;
	logic         req_s1, req_s2, req_s3;
	logic         ack_tgl;
	logic         ack_s1, ack_s2, ack_s3;
	logic         abort_tgl;
	logic         abt_s1, abt_s2, abt_s3;
	logic         txn_s1, txn_s2;
	logic [31:0]  wd_pre;
	logic [6:0]   wd_units;
	logic         wd_fired;
	logic         tick_end;
	logic [1:0]   raw_s1, raw_s2;
	logic [1:0]   filt, filt_q;
	logic [4:0]   filt_cnt [2];
	logic [4:0]   filt_acc;
	logic         scl_fall;
	logic [5:0]   hold_cnt;
	logic [5:0]   hold_cyc;
	cci2c_out_t   out_state;
	logic [9:0]   out_cnt;
	logic [9:0]   dly_cyc;
	logic [9:0]   setup_cyc;
	logic         stretch;
	cci2c_guard_t gstate;
	logic [31:0]  idle_cnt;
	logic [31:0]  idle_lim;
	logic [9:0]   half_cnt;
	logic [3:0]   pulses;
	logic         guard_off;
	logic         activity;

	// Link side: capture remote write and toggle the request
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_hold <= '0;
			req_tgl <= 1'b0;
			link_wr_busy <= 1'b0;
			link_wr_refused <= 1'b0;
		end else begin
			link_wr_refused <= (ack_s2 ^ ack_s3) & rem_refused;
			if (!link_wr_busy && link_wr_req) begin
				wr_hold <= link_wr;
				req_tgl <= ~req_tgl;
				link_wr_busy <= 1'b1;
			end else if (ack_s2 ^ ack_s3) begin
				link_wr_busy <= 1'b0;
			end
		end
	end

	// Link side synchronisers and abort pulse
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			{ack_s1, ack_s2, ack_s3} <= 3'h0;
			{abt_s1, abt_s2, abt_s3} <= 3'h0;
			link_abort <= 1'b0;
		end else begin
			{ack_s1, ack_s2, ack_s3} <= {ack_tgl, ack_s1, ack_s2};
			{abt_s1, abt_s2, abt_s3} <= {abort_tgl, abt_s1, abt_s2};
			link_abort <= abt_s2 ^ abt_s3;
		end
	end

	// System side synchronisers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{req_s1, req_s2, req_s3} <= 3'h0;
			{txn_s1, txn_s2} <= 2'h0;
			raw_s1 <= 2'h3;
			raw_s2 <= 2'h3;
		end else begin
			{req_s1, req_s2, req_s3} <= {req_tgl, req_s1, req_s2};
			{txn_s1, txn_s2} <= {link_txn_active, txn_s1};
			raw_s1 <= bus_in;
			raw_s2 <= raw_s1;
		end
	end

	assign blocked = ctl1[BLOCK_BIT];
	assign rem_go = rem_pend & ~reg_wr;
	assign wr_go = reg_wr | (rem_go & ~blocked);
	assign wr_a = reg_wr ? reg_addr : wr_hold.addr;
	assign wr_d = reg_wr ? reg_wdata : wr_hold.data;

	// Remote write handshake
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rem_pend <= 1'b0;
			ack_tgl <= 1'b0;
			rem_refused <= 1'b0;
		end else if (req_s2 ^ req_s3) begin
			rem_pend <= 1'b1;
		end else if (rem_go) begin
			rem_pend <= 1'b0;
			ack_tgl <= ~ack_tgl;
			rem_refused <= blocked;
		end
	end

	// Register file
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_reg <= RST_LINK_WD;
			ctl1 <= RST_CTL_FIRST;
			ctl2 <= RST_CTL_SECOND;
		end else if (wr_go) begin
			unique case (wr_a)
				ADDR_LINK_WD: wd_reg <= wr_d;
				ADDR_CTL_FIRST: ctl1 <= wr_d;
				ADDR_CTL_SECOND: ctl2 <= wr_d;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				ADDR_LINK_WD: reg_rdata <= wd_reg;
				ADDR_CTL_FIRST: reg_rdata <= ctl1;
				ADDR_CTL_SECOND: reg_rdata <= ctl2;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Link transaction watchdog
	assign tick_end = (wd_pre == 32'(LINK_TICK_CYC - 1));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_pre <= 32'h0;
			wd_units <= 7'h00;
			wd_fired <= 1'b0;
			abort_tgl <= 1'b0;
		end else if (!txn_s2 || wd_reg[WD_OFF_BIT]) begin
			wd_pre <= 32'h0;
			wd_units <= 7'h00;
			wd_fired <= 1'b0;
		end else if (!wd_fired) begin
			wd_pre <= tick_end ? 32'h0 : wd_pre + 32'h1;
			if (tick_end) begin
				wd_units <= wd_units + 7'h01;
				// A zero timeout aborts at the first tick
				if (wd_units + 7'h01 >= wd_reg[WD_TMR_MSB:WD_TMR_LSB]) begin
					wd_fired <= 1'b1;
					abort_tgl <= ~abort_tgl;
				end
			end
		end
	end

	// Glitch filter on both bus inputs
	assign filt_acc = 5'(ctl1[FILT_MSB:FILT_LSB] * FILT_STEP_NS / CLK_NS + 1);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			filt <= 2'h3;
			filt_q <= 2'h3;
			filt_cnt[0] <= 5'h00;
			filt_cnt[1] <= 5'h00;
		end else begin
			filt_q <= filt;
			for (int i = 0; i < 2; i++) begin
				if (raw_s2[i] == filt[i]) begin
					filt_cnt[i] <= 5'h00;
				end else if (filt_cnt[i] + 5'h01 >= filt_acc) begin
					filt[i] <= raw_s2[i];
					filt_cnt[i] <= 5'h00;
				end else begin
					filt_cnt[i] <= filt_cnt[i] + 5'h01;
				end
			end
		end
	end

	// Index 1 is SCL, index 0 is SDA
	assign scl_fall = filt_q[1] & ~filt[1];
	assign hold_cyc = 6'(ctl1[HOLD_MSB:HOLD_LSB] * HOLD_STEP_NS / CLK_NS);

	// SDA input hold after SCL falls
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt <= 6'h00;
			bus_seen <= '1;
		end else begin
			bus_seen.scl <= filt[1];
			if (scl_fall) begin
				hold_cnt <= hold_cyc;
			end else if (hold_cnt != 6'h00) begin
				hold_cnt <= hold_cnt - 6'h01;
			end else begin
				bus_seen.sda <= filt[0];
			end
		end
	end

	// SDA output delay and remote ACK setup
	assign dly_cyc = 10'(cyc_of(DELAY_BASE_NS
		+ DELAY_STEP_NS * int'(ctl2[DELAY_MSB:DELAY_LSB])));
	assign setup_cyc = 10'(cyc_of(SETUP_BASE_NS
		+ SETUP_STEP_NS * int'(ctl2[SETUP_MSB:SETUP_LSB])));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_state <= O_IDLE;
			out_cnt <= 10'h000;
			stretch <= 1'b0;
			bus_oe.sda <= 1'b0;
		end else if (gstate != G_WATCH) begin
			out_state <= O_IDLE;
			stretch <= 1'b0;
			bus_oe.sda <= 1'b0;
		end else begin
			unique case (out_state)
				O_IDLE: begin
					if (scl_fall) begin
						out_state <= O_DELAY;
						out_cnt <= dly_cyc;
						stretch <= txn_s2 & core_ack_cycle;
					end
				end
				O_DELAY: begin
					out_cnt <= out_cnt - 10'h001;
					if (out_cnt == 10'h001) begin
						bus_oe.sda <= core_sda_low;
						out_state <= stretch ? O_SETUP : O_IDLE;
						out_cnt <= setup_cyc;
					end
				end
				O_SETUP: begin
					out_cnt <= out_cnt - 10'h001;
					if (out_cnt == 10'h001) begin
						stretch <= 1'b0;
						out_state <= O_IDLE;
					end
				end
			endcase
		end
	end

	// Bus guard: free detection and hung bus recovery
	assign guard_off = ctl2[GUARD_OFF_BIT];
	assign activity = (filt != filt_q);
	assign idle_lim = ctl2[GUARD_FAST_BIT] ? 32'(GUARD_FAST_CYC)
		: 32'(GUARD_SLOW_CYC);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gstate <= G_WATCH;
			idle_cnt <= 32'h0;
			half_cnt <= 10'h000;
			pulses <= 4'h0;
			bus_free <= 1'b0;
			bus_recovering <= 1'b0;
		end else if (guard_off) begin
			gstate <= G_WATCH;
			idle_cnt <= 32'h0;
			bus_free <= 1'b0;
			bus_recovering <= 1'b0;
		end else begin
			unique case (gstate)
				G_WATCH: begin
					if (activity) begin
						idle_cnt <= 32'h0;
						bus_free <= 1'b0;
					end else if (idle_cnt >= idle_lim - 32'h1) begin
						if (filt[0]) begin
							bus_free <= 1'b1;
						end else begin
							gstate <= G_REC_LO;
							half_cnt <= 10'(RECOVER_HALF_CYC);
							pulses <= 4'h0;
							bus_recovering <= 1'b1;
						end
					end else begin
						idle_cnt <= idle_cnt + 32'h1;
					end
				end
				G_REC_LO: begin
					half_cnt <= half_cnt - 10'h001;
					if (half_cnt == 10'h001) begin
						gstate <= G_REC_HI;
						half_cnt <= 10'(RECOVER_HALF_CYC);
					end
				end
				G_REC_HI: begin
					half_cnt <= half_cnt - 10'h001;
					if (half_cnt == 10'h001) begin
						half_cnt <= 10'(RECOVER_HALF_CYC);
						pulses <= pulses + 4'h1;
						if (pulses == 4'(RECOVER_PULSES - 1)) begin
							gstate <= G_WATCH;
							idle_cnt <= 32'h0;
							bus_recovering <= 1'b0;
						end else begin
							gstate <= G_REC_LO;
						end
					end
				end
				default: gstate <= G_WATCH;
			endcase
		end
	end

	// SCL driver and fixed low levels
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_oe.scl <= 1'b0;
			bus_o <= '0;
		end else begin
			bus_oe.scl <= (gstate == G_REC_LO) | stretch;
			bus_o <= '0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_delay_run;
		(out_state == O_DELAY)[*8];
	endsequence

	sequence s_stretch_run;
		stretch[*8];
	endsequence

	AST_WD_OFF_NO_ABORT: assert property (wd_reg[WD_OFF_BIT] |=> $stable(abort_tgl))
		else $error("link watchdog fired while disabled");
	AST_WD_ABORT_CAUSE: assert property ($changed(abort_tgl) |-> $past(txn_s2)
		&& $past(tick_end) && $past(wd_units) + 7'h01 >= $past(wd_reg[7:1]))
		else $error("link abort without expired timeout");
	AST_BLOCK_REFUSES: assert property (rem_go && blocked |=> rem_refused
		&& $stable(wd_reg) && $stable(ctl1) && $stable(ctl2))
		else $error("blocked remote write changed a register");
	AST_FILTER_STABLE: assert property ($changed(filt[1]) |-> $past(raw_s2[1]) == filt[1]
		&& $past(filt_cnt[1]) + 5'h01 >= $past(filt_acc))
		else $error("filter passed a short pulse");
	AST_HOLD_LOAD: assert property (scl_fall |=> hold_cnt == $past(hold_cyc))
		else $error("sda hold not started on scl fall");
	AST_DELAY_MIN: assert property (out_state == O_IDLE && scl_fall && gstate == G_WATCH
		|=> s_delay_run)
		else $error("sda output delay too short");
	AST_SETUP_STRETCH: assert property ($rose(out_state == O_SETUP) |-> s_stretch_run)
		else $error("ack setup stretch too short");
	AST_NINE_PULSES: assert property (gstate == G_REC_HI && half_cnt == 10'h001
		&& pulses == 4'h8 && !guard_off |=> gstate == G_WATCH && !bus_recovering)
		else $error("recovery did not end after nine pulses");
	AST_GUARD_OFF: assert property (guard_off |=> gstate == G_WATCH && !bus_free)
		else $error("bus guard active while disabled");
	AST_FREE_SDA_HIGH: assert property ($rose(bus_free) |-> $past(filt[0])
		&& !$past(activity))
		else $error("bus free flagged with sda low");

endmodule : cci2c_top

// [src/cci2c_pkg.sv]
package cci2c_pkg;

	// Clock of the register side
	localparam int CLK_NS = 10;

	// Register offsets
	localparam logic [7:0] ADDR_LINK_WD = 8'h08;
	localparam logic [7:0] ADDR_CTL_FIRST = 8'h09;
	localparam logic [7:0] ADDR_CTL_SECOND = 8'h0a;

	// Reset values
	localparam logic [7:0] RST_LINK_WD = 8'hfe;
	localparam logic [7:0] RST_CTL_FIRST = 8'h1e;
	localparam logic [7:0] RST_CTL_SECOND = 8'h10;

	// Field positions
	localparam int WD_TMR_MSB = 7;
	localparam int WD_TMR_LSB = 1;
	localparam int WD_OFF_BIT = 0;
	localparam int BLOCK_BIT = 7;
	localparam int HOLD_MSB = 6;
	localparam int HOLD_LSB = 4;
	localparam int FILT_MSB = 3;
	localparam int FILT_LSB = 0;
	localparam int SETUP_MSB = 7;
	localparam int SETUP_LSB = 4;
	localparam int DELAY_MSB = 3;
	localparam int DELAY_LSB = 2;
	localparam int GUARD_FAST_BIT = 1;
	localparam int GUARD_OFF_BIT = 0;

	// Timing
	localparam int LINK_TICK_NS = 2_000_000;
	localparam int LINK_TICK_CYC = LINK_TICK_NS / CLK_NS;
	localparam int HOLD_STEP_NS = 50;
	localparam int FILT_STEP_NS = 5;
	localparam int SETUP_BASE_NS = 80;
	localparam int SETUP_STEP_NS = 640;
	localparam int DELAY_BASE_NS = 240;
	localparam int DELAY_STEP_NS = 40;
	localparam int GUARD_FAST_NS = 50_000;
	localparam int GUARD_FAST_CYC = GUARD_FAST_NS / CLK_NS;
	localparam int GUARD_SLOW_NS = 1_000_000_000;
	localparam int GUARD_SLOW_CYC = GUARD_SLOW_NS / CLK_NS;
	localparam int RECOVER_HALF_NS = 5_000;
	localparam int RECOVER_HALF_CYC = RECOVER_HALF_NS / CLK_NS;
	localparam int RECOVER_PULSES = 9;

	// Remote register write carried across the link
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} cci2c_wr_t;

	// Local bus line pair
	typedef struct packed {
		logic scl;
		logic sda;
	} cci2c_pins_t;

endpackage : cci2c_pkg

// [tb/cci2c_far.sv]
module cci2c_far (
	// Link side
	input  wire logic                 link_clk,
	input  wire logic                 link_wr_busy,
	input  wire logic                 link_wr_refused,
	input  wire logic                 link_abort,
	output logic                      link_txn_active,
	output logic                      link_wr_req,
	output cci2c_pkg::cci2c_wr_t      link_wr,
	// Local bus device
	output logic                      sda_pull
);
	timeunit 1ns;
	timeprecision 100ps;
	import cci2c_pkg::*;

	initial begin
		link_txn_active = 1'b0;
		link_wr_req = 1'b0;
		link_wr = '0;
		sda_pull = 1'b0;
	end

	// Device on the local bus holding SDA low
	task set_pull(input logic v);
		sda_pull = v;
	endtask : set_pull

	// Remote write, requested for one link cycle, then wait for completion
	task rmt_write(input logic [7:0] a, input logic [7:0] d, output logic refused);
		int n;
		@(posedge link_clk);
		#1;
		link_wr_req = 1'b1;
		link_wr = {a, d};
		@(posedge link_clk);
		#1;
		link_wr_req = 1'b0;
		link_wr = ~link_wr;
		n = 0;
		while (link_wr_busy && n < 100) begin
			@(posedge link_clk);
			#1;
			n++;
		end
		refused = link_wr_refused;
	endtask : rmt_write

	// Open a transaction for len link cycles, report first abort cycle
	task txn(input int len, output int at);
		at = -1;
		@(posedge link_clk);
		#1;
		link_txn_active = 1'b1;
		for (int i = 0; i < len; i++) begin
			@(posedge link_clk);
			#1;
			if (link_abort && at < 0)
				at = i;
		end
		link_txn_active = 1'b0;
	endtask : txn

endmodule : cci2c_far

// [tb/cci2c_top_tb.sv]
module cci2c_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cci2c_pkg::*;

	localparam int TICK = 20;
	localparam int FAST = 50;

	logic               sys_clk, rst_b, link_clk, reg_wr, glitch, core_low, core_ack, scl_low;
	logic [7:0]         reg_addr, reg_wdata, reg_rdata, rv;
	logic               txn_act, wr_req, wr_busy, wr_ref, abort_p, free, rec, pull, rf, prev;
	cci2c_wr_t          wr_bus;
	cci2c_pins_t        bus_in, bus_oe, seen;
	int                 failures, samples_checked, cyc, at, n, p, e;
	logic [7:0]         mdl [3];

	assign bus_in.scl = ~(bus_oe.scl | scl_low);
	assign bus_in.sda = ~(bus_oe.sda | pull | glitch);

	cci2c_top #(.LINK_TICK_CYC(TICK), .GUARD_FAST_CYC(FAST), .GUARD_SLOW_CYC(200),
		.RECOVER_HALF_CYC(4)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.link_txn_active(txn_act), .link_wr_req(wr_req), .link_wr(wr_bus),
		.link_wr_busy(wr_busy), .link_wr_refused(wr_ref), .link_abort(abort_p),
		.core_sda_low(core_low), .core_ack_cycle(core_ack), .bus_in(bus_in), .bus_o(),
		.bus_oe(bus_oe), .bus_seen(seen), .bus_free(free), .bus_recovering(rec));

	cci2c_far far (
		.link_clk(link_clk), .link_wr_busy(wr_busy), .link_wr_refused(wr_ref),
		.link_abort(abort_p), .link_txn_active(txn_act), .link_wr_req(wr_req),
		.link_wr(wr_bus), .sda_pull(pull));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = ~link_clk;
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			complete_run();
		end
	end

	task check(input logic [7:0] s, input logic [7:0] x);
		samples_checked++;
		if (s !== x) begin
			failures++;
			$display("BAD t=%0t seen %h expected %h", $time, s, x);
		end
	endtask : check

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task step;
		@(posedge sys_clk);
		#1;
	endtask : step

	task wr(input logic [7:0] a, input logic [7:0] d);
		step();
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		step();
		reg_wr = 1'b0;
		if (a >= 8'h08 && a <= 8'h0a)
			mdl[a - 8'h08] = d;
	endtask : wr

	// Read back and compare with the model, unmapped places read zero
	task rchk(input logic [7:0] a);
		step();
		reg_addr = a;
		step();
		check(reg_rdata, (a >= 8'h08 && a <= 8'h0a) ? mdl[a - 8'h08] : 8'h00);
	endtask : rchk

	initial begin
		{rst_b, reg_wr, reg_addr, reg_wdata, glitch, core_low, core_ack, scl_low} = '0;
		{failures, samples_checked, cyc} = '0;
		mdl = '{RST_LINK_WD, RST_CTL_FIRST, RST_CTL_SECOND};
		void'($urandom(32'h2e35));
		repeat (10) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		repeat (150) step();
		check(free, 0);
		repeat (100) step();
		check(free, 1);
		for (int a = 8; a <= 11; a++) rchk(a[7:0]);
		for (int i = 8; i <= 11; i++) begin
			wr(i[7:0], 8'($urandom) | ((i == 8) ? 8'h02 : 8'h00));
			rchk(i[7:0]);
		end
		// Short glitch is swallowed, a long low is seen
		wr(8'h09, 8'h1e);
		repeat (20) step();
		glitch = 1'b1;
		repeat (3) step();
		glitch = 1'b0;
		rv = 8'h00;
		repeat (12) begin
			step();
			rv = rv | {7'h00, ~seen.sda};
		end
		check(rv, 0);
		glitch = 1'b1;
		repeat (20) step();
		check(seen.sda, 0);
		glitch = 1'b0;
		// Remote writes, accepted then refused
		far.rmt_write(8'h08, 8'h0c, rf);
		check(rf, 0);
		mdl[0] = 8'h0c;
		rchk(8'h08);
		wr(8'h09, 8'h9e);
		far.rmt_write(8'h08, 8'h44, rf);
		check(rf, 1);
		rchk(8'h08);
		// Link watchdog with two ticks, then switched off
		wr(8'h08, 8'h04);
		far.txn(30, at);
		e = 2 * TICK * 10 / 64;
		check(at >= e - 2 && at <= e + 8, 1);
		wr(8'h08, 8'h05);
		far.txn(30, at);
		check(at < 0, 1);
		// Bus guard in fast mode
		wr(8'h0a, 8'h12);
		n = 0;
		while (!free && n < FAST * 3) begin
			step();
			n++;
		end
		check(free, 1);
		far.set_pull(1'b1);
		n = 0;
		while (!rec && n < FAST * 3) begin
			step();
			n++;
		end
		check(rec, 1);
		check(n > FAST - 5 && n < FAST + 20, 1);
		p = 0;
		prev = 1'b0;
		n = 0;
		do begin
			if (bus_oe.scl && !prev)
				p++;
			prev = bus_oe.scl;
			step();
			n++;
		end while (rec && n < 400);
		check(p, RECOVER_PULSES);
		far.set_pull(1'b0);
		wr(8'h0a, 8'h13);
		far.set_pull(1'b1);
		rv = 8'h00;
		repeat (FAST * 3) begin
			step();
			rv = rv | {7'h00, rec | free};
		end
		check(rv, 0);
		far.set_pull(1'b0);
		// SCL falls from outside, SDA output follows after the delay
		core_low = 1'b1;
		core_ack = 1'($urandom);
		scl_low = 1'b1;
		n = 0;
		while (!bus_oe.sda && n < 100) begin
			step();
			n++;
		end
		check(n >= 32 && n <= 40, 1);
		check(bus_oe.sda, 1);
		complete_run();
	end

endmodule : cci2c_top_tb
